// *** src/flash_status_protect_regs.vh ***
// Opcodes, field positions, reset values and busy counts of the status bank
`ifndef FLASH_STATUS_PROTECT_REGS_VH
`define FLASH_STATUS_PROTECT_REGS_VH

// ----------------------------------------------------------------------
// Serial opcodes
// ----------------------------------------------------------------------
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_PROG 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE 8'hC7
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_BLOCK_UNLOCK 8'h39
`define OP_BLOCK_LOCK 8'h36

// ----------------------------------------------------------------------
// Field positions in the data byte of a status write
// ----------------------------------------------------------------------
`define S2_INVERT 6
`define S2_QUAD 1
`define S2_LOCK_UPPER 0
`define S3_HOLD_RESET 7
`define S3_FAST 4
`define S3_SCHEME 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SR1_RESET 8'h00
`define SR2_RESET 8'h00
`define SR3_RESET 8'h10
`define PIN_RESET 4'hA

// ----------------------------------------------------------------------
// Busy durations in CLK cycles
// ----------------------------------------------------------------------
`define T_WRSR_CYC 16'h00C8
`define T_PROG_CYC 16'h0190
`define T_ERASE_CYC 16'h03E8
`define T_CHIP_CYC 16'h07D0

`endif

// *** src/flash_status_protect_regs.v ***
// Status, configuration and write protection bank of a serial NOR flash
`timescale 1ns/1ps
`include "flash_status_protect_regs.vh"

module flash_status_protect_regs #(
  parameter [15:0] WRSR_CYCLES = `T_WRSR_CYC,
  parameter [15:0] PROG_CYCLES = `T_PROG_CYC,
  parameter [15:0] ERASE_CYCLES = `T_ERASE_CYC,
  parameter [15:0] CHIP_CYCLES = `T_CHIP_CYC
) (
  input wire CLK,
  input wire RESET,
  input wire SCLK,
  input wire CS_N,
  input wire SI,
  input wire WP_N,
  output reg SO,
  output reg SO_OE,
  output reg BUSY,
  output reg ARRAY_OP_START,
  output reg WP_FUNCTION_ON,
  output reg HOLD_FUNCTION_ON,
  output reg RESET_FUNCTION_ON,
  output reg QUAD_IO_ON,
  output reg [1:0] DRIVE_STRENGTH,
  output reg [6:0] DRIVE_PERCENT,
  output reg FAST_CLOCK_MODE,
  output reg [2:0] SECURE_AREA_LOCK
);

  // --------------------------------------------------------------------
  // Operation kinds held while busy
  // --------------------------------------------------------------------
  localparam [1:0] KIND_NONE = 2'h0, KIND_PROG = 2'h1;
  localparam [1:0] KIND_ERASE = 2'h2, KIND_WRSR = 2'h3;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [3:0] in_s1, in_s2, in_s3, pin;
  reg sclk_q, cs_q, rd_active, rst_en;
  reg [7:0] shreg, opcode, b1, b2, b3, txbuf;
  reg [2:0] bitcnt, bytecnt, txcnt;
  reg busy, write_enable_latch, top_bottom_select, small_unit_granularity;
  reg status_lock_mode_lower, status_lock_mode_upper, protect_invert;
  reg erase_suspended_flag, program_suspended_flag, quad_io_enable;
  reg hold_or_reset_select, fast_clock_mode, protect_scheme_select;
  reg [15:0] busy_cnt;
  reg [1:0] kind, output_strength;
  reg [2:0] block_protect_level, secure_area_lock;
  reg [255:0] block_lock;

  // --------------------------------------------------------------------
  // Level map lookup, in 4 KB sector units
  // --------------------------------------------------------------------
  function prot_hit;
    input [11:0] sector;
    input gran;
    input tb;
    input inv;
    input [2:0] lvl;
    reg [12:0] n;
    reg hit;
    begin
      if (gran) begin
        // Sector sizes stop growing at 32 KB
        if (lvl[2])
          n = 13'h0008;
        else
          n = 13'h0001 << (lvl[1:0] - 2'h1);
      end else begin
        n = 13'h0020 << lvl;
      end
      if (lvl == 3'h0)
        hit = 1'b0;
      else if (lvl == 3'h7)
        hit = 1'b1;
      else if (tb)
        hit = ({1'b0, sector} < n);
      else
        hit = ({1'b0, sector} >= (13'h1000 - n));
      prot_hit = hit ^ inv;
    end
  endfunction

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire sclk_rise = pin[0] & ~sclk_q;
  wire sclk_fall = ~pin[0] & sclk_q;
  wire cs_rise = pin[1] & ~cs_q;
  wire [7:0] byte_in = {shreg[6:0], pin[2]};
  wire any_sus = erase_suspended_flag | program_suspended_flag;
  wire [1:0] lock_mode = {status_lock_mode_upper, status_lock_mode_lower};

  wire [7:0] status_one = {status_lock_mode_lower, small_unit_granularity,
    top_bottom_select, block_protect_level, write_enable_latch, busy};
  wire [7:0] status_two = {erase_suspended_flag, protect_invert,
    secure_area_lock, program_suspended_flag, quad_io_enable,
    status_lock_mode_upper};
  wire [7:0] status_three_config = {hold_or_reset_select, output_strength,
    fast_clock_mode, 1'b0, protect_scheme_select, 2'b00};
  wire [7:0] rd_value = (opcode == `OP_RDSR2) ? status_two :
    (opcode == `OP_RDSR3) ? status_three_config : status_one;
  wire is_read = (byte_in == `OP_RDSR1) | (byte_in == `OP_RDSR2) |
    (byte_in == `OP_RDSR3);

  // Protect pin counts only while it is not a data line
  wire wp_high = quad_io_enable | pin[3];
  wire mode_ok = (lock_mode == 2'b00) |
    ((lock_mode == 2'b01) & wp_high);
  wire sr_write_ok = write_enable_latch & mode_ok;
  wire wr_sr2 = ((opcode == `OP_WRSR1) & (bytecnt >= 3'h3)) |
    (opcode == `OP_WRSR2);
  wire [7:0] sr2_data = (opcode == `OP_WRSR1) ? b2 : b1;

  // Block erase checks both ends of its 64 KB span
  wire [11:0] sec_lo = (opcode == `OP_BLOCK_ERASE) ? {b1, 4'h0} :
    {b1, b2[7:4]};
  wire [11:0] sec_hi = (opcode == `OP_BLOCK_ERASE) ? {b1, 4'hF} :
    {b1, b2[7:4]};
  wire map_prot = prot_hit(sec_lo, small_unit_granularity,
    top_bottom_select, protect_invert, block_protect_level) |
    prot_hit(sec_hi, small_unit_granularity, top_bottom_select,
    protect_invert, block_protect_level);
  wire map_any = ~(((block_protect_level == 3'h0) & ~protect_invert) |
    ((block_protect_level == 3'h7) & protect_invert));
  wire chip_prot = protect_scheme_select ? (|block_lock) : map_any;
  wire area_prot = (opcode == `OP_CHIP_ERASE) ? chip_prot :
    (protect_scheme_select ? block_lock[b1] : map_prot);

  wire is_array_op = (opcode == `OP_PROG) |
    (opcode == `OP_SECTOR_ERASE) | (opcode == `OP_BLOCK_ERASE) |
    (opcode == `OP_CHIP_ERASE);
  wire array_len_ok = (opcode == `OP_PROG) ? (bytecnt >= 3'h5) :
    (opcode == `OP_CHIP_ERASE) ? (bytecnt == 3'h1) : (bytecnt >= 3'h4);
  wire [15:0] array_cycles = (opcode == `OP_PROG) ? PROG_CYCLES :
    (opcode == `OP_CHIP_ERASE) ? CHIP_CYCLES : ERASE_CYCLES;

  // --------------------------------------------------------------------
  // Serial engine and register bank
  // --------------------------------------------------------------------
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      in_s1 <= `PIN_RESET;
      in_s2 <= `PIN_RESET;
      in_s3 <= `PIN_RESET;
      pin <= `PIN_RESET;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      bytecnt <= 3'h0;
      opcode <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      b3 <= 8'h00;
      rd_active <= 1'b0;
      txcnt <= 3'h0;
      txbuf <= 8'h00;
      rst_en <= 1'b0;
      SO <= 1'b0;
      SO_OE <= 1'b0;
      ARRAY_OP_START <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 16'h0000;
      kind <= KIND_NONE;
      // Power cycle: volatile bits and lock modes back to defaults
      write_enable_latch <= 1'b0;
      block_protect_level <= 3'h0;
      top_bottom_select <= 1'b0;
      small_unit_granularity <= 1'b0;
      status_lock_mode_lower <= 1'b0;
      status_lock_mode_upper <= 1'b0;
      protect_invert <= 1'b0;
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
      secure_area_lock <= 3'h0;
      quad_io_enable <= 1'b0;
      hold_or_reset_select <= 1'b0;
      output_strength <= 2'h0;
      fast_clock_mode <= 1'b1;
      protect_scheme_select <= 1'b0;
      block_lock <= {256{1'b1}};
    end else begin
      // Three stage sampling; a level counts once stages two and three agree
      in_s1 <= {WP_N, SI, CS_N, SCLK};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      pin <= (in_s2 & in_s3) | (pin & (in_s2 ^ in_s3));
      sclk_q <= pin[0];
      cs_q <= pin[1];
      ARRAY_OP_START <= 1'b0;

      if (busy) begin
        if (busy_cnt == 16'h0000) begin
          busy <= 1'b0;
          kind <= KIND_NONE;
        end else begin
          busy_cnt <= busy_cnt - 16'h0001;
        end
      end
      // Frame handling, mode 0: sample on rise, shift out on fall
      if (pin[1]) begin
        bitcnt <= 3'h0;
        bytecnt <= 3'h0;
        rd_active <= 1'b0;
        SO_OE <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shreg <= byte_in;
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            if (bytecnt != 3'h7)
              bytecnt <= bytecnt + 3'h1;
            case (bytecnt)
              3'h0: opcode <= byte_in;
              3'h1: b1 <= byte_in;
              3'h2: b2 <= byte_in;
              3'h3: b3 <= byte_in;
              default: ;
            endcase
            // Status reads are honoured even while busy
            if ((bytecnt == 3'h0) & is_read) begin
              rd_active <= 1'b1;
              txcnt <= 3'h0;
            end
          end
        end
        // Each new byte reloads live status so polling sees busy drop
        if (sclk_fall & rd_active) begin
          SO_OE <= 1'b1;
          txcnt <= txcnt + 3'h1;
          if (txcnt == 3'h0) begin
            SO <= rd_value[7];
            txbuf <= {rd_value[6:0], 1'b0};
          end else begin
            SO <= txbuf[7];
            txbuf <= {txbuf[6:0], 1'b0};
          end
        end
      end
      // Commands act at frame end and only on a byte boundary
      if (cs_rise & (bitcnt == 3'h0) & (bytecnt != 3'h0)) begin
        rst_en <= ~busy & (opcode == `OP_RESET_ENABLE);
        if (busy) begin
          // Everything but suspend of an array operation is dropped
          if ((opcode == `OP_SUSPEND) & (kind != KIND_WRSR)) begin
            busy <= 1'b0;
            if (kind == KIND_ERASE)
              erase_suspended_flag <= 1'b1;
            else
              program_suspended_flag <= 1'b1;
          end
        end else begin
          case (opcode)
            `OP_WREN: write_enable_latch <= 1'b1;
            `OP_WRDI: write_enable_latch <= 1'b0;
            `OP_WRSR1, `OP_WRSR2, `OP_WRSR3: begin
              // A refused write leaves every bit and busy alone
              if (sr_write_ok & (bytecnt >= 3'h2) & ~any_sus) begin
                write_enable_latch <= 1'b0;
                busy <= 1'b1;
                busy_cnt <= WRSR_CYCLES - 16'h0001;
                kind <= KIND_WRSR;
                if (opcode == `OP_WRSR1) begin
                  status_lock_mode_lower <= b1[7];
                  small_unit_granularity <= b1[6];
                  top_bottom_select <= b1[5];
                  block_protect_level <= b1[4:2];
                end
                if (wr_sr2) begin
                  protect_invert <= sr2_data[`S2_INVERT];
                  // One-time bits only accumulate
                  secure_area_lock <= secure_area_lock |
                    sr2_data[5:3];
                  quad_io_enable <= sr2_data[`S2_QUAD];
                  status_lock_mode_upper <= sr2_data[`S2_LOCK_UPPER];
                end
                if (opcode == `OP_WRSR3) begin
                  hold_or_reset_select <= b1[`S3_HOLD_RESET];
                  output_strength <= b1[6:5];
                  fast_clock_mode <= b1[`S3_FAST];
                  protect_scheme_select <= b1[`S3_SCHEME];
                end
              end
            end
            `OP_PROG, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE,
            `OP_CHIP_ERASE: begin
              if (write_enable_latch & array_len_ok & ~any_sus) begin
                write_enable_latch <= 1'b0;
                // Protected targets are dropped without going busy
                if (~area_prot) begin
                  busy <= 1'b1;
                  busy_cnt <= array_cycles - 16'h0001;
                  kind <= (opcode == `OP_PROG) ? KIND_PROG : KIND_ERASE;
                  ARRAY_OP_START <= 1'b1;
                end
              end
            end
            `OP_RESUME: begin
              if (any_sus) begin
                erase_suspended_flag <= 1'b0;
                program_suspended_flag <= 1'b0;
                busy <= 1'b1;
              end
            end
            `OP_RESET: begin
              if (rst_en) begin
                write_enable_latch <= 1'b0;
                erase_suspended_flag <= 1'b0;
                program_suspended_flag <= 1'b0;
                kind <= KIND_NONE;
                busy_cnt <= 16'h0000;
                block_lock <= {256{1'b1}};
                if (lock_mode == 2'b10) begin
                  status_lock_mode_upper <= 1'b0;
                  status_lock_mode_lower <= 1'b0;
                end
              end
            end
            `OP_BLOCK_UNLOCK, `OP_BLOCK_LOCK: begin
              if (write_enable_latch & (bytecnt >= 3'h4)) begin
                write_enable_latch <= 1'b0;
                block_lock[b1] <= (opcode == `OP_BLOCK_LOCK);
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Registered copies of the configuration for the pad logic
  // --------------------------------------------------------------------
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      BUSY <= 1'b0;
      WP_FUNCTION_ON <= 1'b1;
      HOLD_FUNCTION_ON <= 1'b1;
      RESET_FUNCTION_ON <= 1'b0;
      QUAD_IO_ON <= 1'b0;
      DRIVE_STRENGTH <= 2'h0;
      DRIVE_PERCENT <= 7'h32;
      FAST_CLOCK_MODE <= 1'b1;
      SECURE_AREA_LOCK <= 3'h0;
    end else begin
      BUSY <= busy;
      WP_FUNCTION_ON <= ~quad_io_enable;
      QUAD_IO_ON <= quad_io_enable;
      // Quad mode overrides the hold/reset choice
      HOLD_FUNCTION_ON <= ~quad_io_enable & ~hold_or_reset_select;
      RESET_FUNCTION_ON <= ~quad_io_enable & hold_or_reset_select;
      DRIVE_STRENGTH <= output_strength;
      case (output_strength)
        2'h0: DRIVE_PERCENT <= 7'h32;
        2'h1: DRIVE_PERCENT <= 7'h19;
        2'h2: DRIVE_PERCENT <= 7'h4B;
        2'h3: DRIVE_PERCENT <= 7'h64;
        default: DRIVE_PERCENT <= 7'h32;
      endcase
      FAST_CLOCK_MODE <= fast_clock_mode;
      SECURE_AREA_LOCK <= secure_area_lock;
    end
  end

endmodule

// *** verification/fsp_checker_asserts.sv ***
// Concurrent checks on the ports of the status and protection bank
`timescale 1ns/1ps
module fsp_checker #(
  parameter [15:0] WRSR_CYCLES = 16'h00C8,
  parameter [15:0] PROG_CYCLES = 16'h0190,
  parameter [15:0] ERASE_CYCLES = 16'h03E8,
  parameter [15:0] CHIP_CYCLES = 16'h07D0
) (
  input wire CLK,
  input wire RESET,
  input wire CS_N,
  input wire SO_OE,
  input wire BUSY,
  input wire ARRAY_OP_START,
  input wire WP_FUNCTION_ON,
  input wire HOLD_FUNCTION_ON,
  input wire RESET_FUNCTION_ON,
  input wire QUAD_IO_ON,
  input wire [1:0] DRIVE_STRENGTH,
  input wire [6:0] DRIVE_PERCENT,
  input wire [2:0] SECURE_AREA_LOCK
);
  localparam [15:0] M1 = WRSR_CYCLES > PROG_CYCLES ?
    WRSR_CYCLES : PROG_CYCLES;
  localparam [15:0] M2 = ERASE_CYCLES > CHIP_CYCLES ?
    ERASE_CYCLES : CHIP_CYCLES;
  localparam [15:0] LONGEST = (M1 > M2 ? M1 : M2) + 16'h0010;
  reg [15:0] busy_len;
  // ----------------------------------------------------------------
  // Busy run length; a suspend ends the run, so no run is longer
  // ----------------------------------------------------------------
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      busy_len <= 16'h0000;
    end else if (BUSY) begin
      busy_len <= busy_len + 16'h0001;
    end else begin
      busy_len <= 16'h0000;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_frame_end;
    $rose(CS_N);
  endsequence
  sequence s_busy_soon;
    ##[0:3] BUSY;
  endsequence
  a_op_busy: assert property (ARRAY_OP_START |-> s_busy_soon)
    else $error("busy missing after operation start");
  a_busy_at_rest: assert property ($rose(BUSY) |-> CS_N)
    else $error("busy rose inside a frame");
  a_busy_min: assert property ($rose(BUSY) |=> BUSY [*8])
    else $error("busy dropped too early");
  a_busy_bound: assert property (busy_len <= LONGEST)
    else $error("busy outlasts the longest operation");
  a_op_not_busy: assert property (ARRAY_OP_START |-> !BUSY)
    else $error("operation started while busy");
  a_quad_pins: assert property (QUAD_IO_ON |->
    !WP_FUNCTION_ON && !HOLD_FUNCTION_ON && !RESET_FUNCTION_ON)
    else $error("pin functions active in quad mode");
  a_hold_or_reset: assert property (!QUAD_IO_ON |->
    WP_FUNCTION_ON && (HOLD_FUNCTION_ON ^ RESET_FUNCTION_ON))
    else $error("hold and reset selection broken");
  a_drive_pct: assert property (DRIVE_PERCENT ==
    (DRIVE_STRENGTH == 2'h0 ? 7'h32 : DRIVE_STRENGTH == 2'h1 ? 7'h19 :
    DRIVE_STRENGTH == 2'h2 ? 7'h4B : 7'h64))
    else $error("drive percent does not match code");
  a_lock_sticky: assert property ((SECURE_AREA_LOCK &
    $past(SECURE_AREA_LOCK)) == $past(SECURE_AREA_LOCK))
    else $error("secure area lock cleared");
  a_pulse_single: assert property (ARRAY_OP_START |=> !ARRAY_OP_START)
    else $error("start pulse longer than one cycle");
  a_oe_release: assert property (s_frame_end |-> ##[1:8] !SO_OE)
    else $error("output enable held after frame end");
endmodule

bind flash_status_protect_regs fsp_checker #(
  .WRSR_CYCLES(WRSR_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)
) u_checker (
  .CLK(CLK), .RESET(RESET), .CS_N(CS_N), .SO_OE(SO_OE), .BUSY(BUSY),
  .ARRAY_OP_START(ARRAY_OP_START), .WP_FUNCTION_ON(WP_FUNCTION_ON),
  .HOLD_FUNCTION_ON(HOLD_FUNCTION_ON),
  .RESET_FUNCTION_ON(RESET_FUNCTION_ON), .QUAD_IO_ON(QUAD_IO_ON),
  .DRIVE_STRENGTH(DRIVE_STRENGTH), .DRIVE_PERCENT(DRIVE_PERCENT),
  .SECURE_AREA_LOCK(SECURE_AREA_LOCK)
);

// *** verification/spi_host_model.sv ***
// Host side of the serial link: mode 0 frames on one data line
`timescale 1ns/1ps
module spi_host_model (
  input wire CLK,
  input wire SO,
  input wire SO_OE,
  output reg SCLK,
  output reg CS_N,
  output reg SI
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  // ----------------------------------------------------------------
  // One frame: nb bytes out, MSB first, then nr bytes read back
  // ----------------------------------------------------------------
  // Clock stands low between frames; 8 CLK per bit
  task xfer(input [31:0] d, input integer nb, input integer nr,
    output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      @(posedge CLK) CS_N <= 1'b0;
      for (i = 0; i < 8 * (nb + nr); i = i + 1) begin
        @(posedge CLK) SI <= (i < 8 * nb) ? d[31 - i] : ~SI;
        repeat (2) @(posedge CLK);
        @(posedge CLK) SCLK <= 1'b1;
        repeat (3) @(posedge CLK);
        // Late sample: output moves cycles after the falling edge
        if (i >= 8 * nb) q = {q[6:0], SO_OE ? SO : 1'bx};
        @(posedge CLK) SCLK <= 1'b0;
      end
      @(posedge CLK) CS_N <= 1'b1;
      SI <= ~SI;
      repeat (10) @(posedge CLK);
    end
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the status and protection bank
`timescale 1ns/1ps
`include "flash_status_protect_regs.vh"
module tb;
  reg CLK;
  reg RESET;
  reg WP_N;
  wire SCLK, CS_N, SI, SO, SO_OE, BUSY, ARRAY_OP_START, QUAD_IO_ON;
  wire WP_FUNCTION_ON, HOLD_FUNCTION_ON, RESET_FUNCTION_ON, FAST_CLOCK_MODE;
  wire [1:0] DRIVE_STRENGTH;
  wire [6:0] DRIVE_PERCENT;
  wire [2:0] SECURE_AREA_LOCK;
  integer n_errors, n_checks, n_ops, cyc, i;
  reg [31:0] seed;
  reg [7:0] q, v;
  wire [7:0] pins = {1'b0, WP_FUNCTION_ON, HOLD_FUNCTION_ON,
    RESET_FUNCTION_ON, QUAD_IO_ON, FAST_CLOCK_MODE, DRIVE_STRENGTH};
  // Busy counts kept short; all but the chip erase count longer than a read plus a command
  flash_status_protect_regs #(
    .WRSR_CYCLES(16'h012C), .PROG_CYCLES(16'h012C),
    .ERASE_CYCLES(16'h012C), .CHIP_CYCLES(16'h0014)
  ) dut (
    .CLK(CLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N), .SI(SI),
    .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE), .BUSY(BUSY),
    .ARRAY_OP_START(ARRAY_OP_START), .WP_FUNCTION_ON(WP_FUNCTION_ON),
    .HOLD_FUNCTION_ON(HOLD_FUNCTION_ON),
    .RESET_FUNCTION_ON(RESET_FUNCTION_ON), .QUAD_IO_ON(QUAD_IO_ON),
    .DRIVE_STRENGTH(DRIVE_STRENGTH), .DRIVE_PERCENT(DRIVE_PERCENT),
    .FAST_CLOCK_MODE(FAST_CLOCK_MODE), .SECURE_AREA_LOCK(SECURE_AREA_LOCK)
  );
  spi_host_model host (.CLK(CLK), .SO(SO), .SO_OE(SO_OE), .SCLK(SCLK),
    .CS_N(CS_N), .SI(SI));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] pins_exp(input [7:0] s2, input [7:0] s3);
    reg qd;
    begin
      qd = s2[`S2_QUAD];
      pins_exp = {1'b0, ~qd, ~qd & ~s3[`S3_HOLD_RESET],
        ~qd & s3[`S3_HOLD_RESET], qd, s3[`S3_FAST], s3[6:5]};
    end
  endfunction
  function [7:0] pct(input [1:0] c);
    pct = (c == 2'h0) ? 8'h32 : (c == 2'h1) ? 8'h19 :
      (c == 2'h2) ? 8'h4B : 8'h64;
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task op(input [7:0] c);
    host.xfer({c, 24'h0}, 1, 0, q);
  endtask
  task rd(input [7:0] c, input [7:0] exp);
    begin
      host.xfer({c, 24'h0}, 1, 1, q);
      chk(q, exp);
    end
  endtask
  task wsr(input [7:0] c, input [7:0] d);
    begin
      op(`OP_WREN);
      host.xfer({c, d, 16'h0}, 2, 0, q);
    end
  endtask
  task idle;
    integer k;
    begin
      k = 0;
      while (BUSY !== 1'b0 && k < 3000) begin
        @(posedge CLK);
        k = k + 1;
      end
      chk({7'h00, BUSY}, 8'h00);
    end
  endtask
  task erase(input [7:0] blk, input [7:0] go);
    integer n0;
    begin
      n0 = n_ops;
      op(`OP_WREN);
      host.xfer({`OP_SECTOR_ERASE, blk, 16'h0}, 4, 0, q);
      n0 = n_ops - n0;
      chk({7'h00, BUSY}, go);
      chk(n0[7:0], go);
    end
  endtask
  task pwr;
    begin
      RESET <= 1'b1;
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      repeat (6) @(posedge CLK);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  // Cycle ceiling well above the expected run of some 22000 cycles
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (ARRAY_OP_START === 1'b1) n_ops = n_ops + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    RESET = 1'b1;
    WP_N = 1'b1;
    n_errors = 0;
    n_checks = 0;
    n_ops = 0;
    cyc = 0;
    seed = 32'hB7295DA2;
    pwr;
    rd(`OP_RDSR1, 8'h00);
    rd(`OP_RDSR2, 8'h00);
    rd(`OP_RDSR3, 8'h10);
    chk(pins, pins_exp(8'h00, 8'h10));
    host.xfer({`OP_WRSR1, 24'h5C0000}, 2, 0, q);
    chk({7'h00, BUSY}, 8'h00);
    rd(`OP_RDSR1, 8'h00);
    op(`OP_WREN);
    rd(`OP_RDSR1, 8'h02);
    op(`OP_WRDI);
    rd(`OP_RDSR1, 8'h00);
    $display("test defaults and latch done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h7C : seed[7:0] & 8'h7C;
      wsr(`OP_WRSR1, v);
      chk({7'h00, BUSY}, 8'h01);
      rd(`OP_RDSR1, v | 8'h01);
      op(`OP_WREN);
      idle;
      rd(`OP_RDSR1, v);
    end
    for (i = 0; i < 4; i = i + 1) begin
      v = {i[1], i[1:0], ~i[0], 4'h0};
      wsr(`OP_WRSR3, v);
      idle;
      rd(`OP_RDSR3, v);
      chk(pins, pins_exp(8'h00, v));
      chk({1'b0, DRIVE_PERCENT}, pct(i[1:0]));
    end
    wsr(`OP_WRSR3, 8'h10);
    idle;
    $display("test register writes done");
    wsr(`OP_WRSR1, 8'h00);
    idle;
    wsr(`OP_WRSR2, 8'h6A);
    idle;
    rd(`OP_RDSR2, 8'h6A);
    chk({5'h00, SECURE_AREA_LOCK}, 8'h05);
    chk(pins, pins_exp(8'h6A, 8'h10));
    erase(8'h12, 8'h00);
    rd(`OP_RDSR1, 8'h00);
    wsr(`OP_WRSR2, 8'h00);
    idle;
    rd(`OP_RDSR2, 8'h28);
    wsr(`OP_WRSR1, 8'h04);
    idle;
    erase(8'hFC, 8'h00);
    wsr(`OP_WRSR1, 8'h44);
    idle;
    erase(8'hFC, 8'h01);
    idle;
    wsr(`OP_WRSR1, 8'h24);
    idle;
    erase(8'h00, 8'h00);
    erase(8'hFC, 8'h01);
    op(`OP_SUSPEND);
    rd(`OP_RDSR2, 8'hA8);
    op(`OP_RESUME);
    rd(`OP_RDSR2, 8'h28);
    idle;
    rd(`OP_RDSR1, 8'h24);
    wsr(`OP_WRSR1, 8'h00);
    idle;
    wsr(`OP_WRSR3, 8'h14);
    idle;
    erase(8'h12, 8'h00);
    op(`OP_WREN);
    host.xfer({`OP_BLOCK_UNLOCK, 24'h120000}, 4, 0, q);
    erase(8'h12, 8'h01);
    idle;
    $display("test protection done");
    wsr(`OP_WRSR1, 8'h80);
    idle;
    @(posedge CLK) WP_N <= 1'b0;
    wsr(`OP_WRSR1, 8'hA4);
    chk({7'h00, BUSY}, 8'h00);
    rd(`OP_RDSR1, 8'h82);
    @(posedge CLK) WP_N <= 1'b1;
    wsr(`OP_WRSR1, 8'hA4);
    idle;
    rd(`OP_RDSR1, 8'hA4);
    wsr(`OP_WRSR1, 8'h08);
    idle;
    @(posedge CLK) WP_N <= 1'b0;
    wsr(`OP_WRSR1, 8'h0C);
    idle;
    rd(`OP_RDSR1, 8'h0C);
    @(posedge CLK) WP_N <= 1'b1;
    wsr(`OP_WRSR2, 8'h29);
    idle;
    wsr(`OP_WRSR1, 8'h00);
    rd(`OP_RDSR1, 8'h0E);
    op(`OP_RESET_ENABLE);
    op(`OP_RESET);
    rd(`OP_RDSR2, 8'h28);
    wsr(`OP_WRSR2, 8'h29);
    idle;
    pwr;
    rd(`OP_RDSR2, 8'h00);
    wsr(`OP_WRSR1, 8'h80);
    idle;
    wsr(`OP_WRSR2, 8'h01);
    idle;
    wsr(`OP_WRSR1, 8'h00);
    chk({7'h00, BUSY}, 8'h00);
    rd(`OP_RDSR1, 8'h82);
    op(`OP_WREN);
    host.xfer({`OP_PROG, 24'h0}, 4, 1, q);
    chk({7'h00, BUSY}, 8'h01);
    op(`OP_SUSPEND);
    rd(`OP_RDSR2, 8'h05);
    op(`OP_RESUME);
    idle;
    rd(`OP_RDSR2, 8'h01);
    op(`OP_WREN);
    host.xfer({`OP_CHIP_ERASE, 24'h0}, 1, 0, q);
    chk({7'h00, BUSY}, 8'h01);
    idle;
    $display("test lock modes done");
    results;
  end
endmodule
